// ---- hdl/csf_status_flags.v ----
// csf_status_flags.v: cpu status flags register with alu flag update and software access
// assumes a core execution unit presents operands with per-flag update strobes, sync to sys_clk
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`include "csf_defs.vh"

module csf_status_flags #(
   parameter DATA_W = 16
) (
   input  wire                    sys_clk,
   input  wire                    reset_n,
   input  wire [`CSF_ADDR_W-1:0]  reg_addr,
   input  wire [15:0]             reg_wdata,
   input  wire                    reg_wr,
   input  wire                    reg_rd,
   output reg  [15:0]             reg_rdata,
   input  wire                    alu_valid,
   input  wire                    alu_byte_op,
   input  wire [DATA_W-1:0]       alu_op_a,
   input  wire [DATA_W-1:0]       alu_op_b,
   input  wire                    alu_carry_in,
   input  wire                    alu_subtract,
   input  wire                    upd_half_carry,
   input  wire                    upd_neg,
   input  wire                    upd_excess,
   input  wire                    upd_zero,
   input  wire                    upd_carry,
   input  wire                    repeat_running,
   input  wire                    ipl_load,
   input  wire [2:0]              ipl_load_val,
   input  wire                    ipl_level_bit3,
   output reg  [DATA_W-1:0]       alu_result_r,
   output wire [15:0]             status_word,
   output wire [3:0]              cpu_level,
   output wire                    user_irq_disabled
);

   // flag storage
   reg        half_carry_flag_r;
   reg        neg_flag_r;
   reg        signed_excess_flag_r;
   reg        zero_flag_r;
   reg        carry_flag_r;
   reg [2:0]  cpu_priority_level_r;
   reg        nesting_disable_bit_r;

   reg        half_carry_flag_nxt;
   reg        neg_flag_nxt;
   reg        signed_excess_flag_nxt;
   reg        zero_flag_nxt;
   reg        carry_flag_nxt;
   reg [2:0]  cpu_priority_level_nxt;
   reg [DATA_W-1:0] alu_result_nxt;

   // width select shared by the sign, carry and half-carry sources; the zero flag has its own width test
   function sel_width;
      input byte_op;
      input byte_val;
      input word_val;
      begin
         if (byte_op) begin
            sel_width = byte_val;
         end else begin
            sel_width = word_val;
         end
      end
   endfunction

   // signed overflow: operands agree in sign and the result does not
   function signed_excess;
      input sa;
      input sb;
      input sr;
      begin
         signed_excess = (sa == sb) && (sr != sa);
      end
   endfunction

   // zero test of the selected width; the upper byte is ignored for byte ops
   function result_is_zero;
      input              byte_op;
      input [DATA_W-1:0] res;
      begin
         if (byte_op) begin
            result_is_zero = (res[7:0] == 8'h00);
         end else begin
            result_is_zero = (res == {DATA_W{1'b0}});
         end
      end
   endfunction

   // status word layout; bits 15..9 are unimplemented and always read zero
   function [15:0] pack_status;
      input       half;
      input [2:0] level;
      input       rpt;
      input       neg;
      input       excess;
      input       zero;
      input       carry;
      begin
         pack_status = {7'h00, half, level, rpt, neg, excess, zero, carry};
      end
   endfunction

   // read mux for the plain register port; unmapped indices read zero
   function [15:0] read_mux;
      input [`CSF_ADDR_W-1:0] addr;
      input [15:0]            status;
      input                   nest;
      begin
         case (addr)
            `CSF_OFS_STATUS:    read_mux = status;
            `CSF_OFS_NEST_CTRL: read_mux = {15'h0000, nest};
            default:            read_mux = 16'h0000;
         endcase
      end
   endfunction

   // adder datapath; subtraction adds the inverted operand, carry means no borrow
   wire [DATA_W-1:0] b_eff = alu_subtract ? ~alu_op_b : alu_op_b;
   wire [DATA_W:0]   sum_full = {1'b0, alu_op_a} + {1'b0, b_eff} + {{DATA_W{1'b0}}, alu_carry_in};
   wire [8:0]        low_byte = {1'b0, alu_op_a[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, alu_carry_in};
   wire [4:0]        low_nib = {1'b0, alu_op_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, alu_carry_in};

   // selected width: byte ops look at bit 7, word ops at the msb; half carry is the carry out of bit 3 (byte) or bit 7 (word)
   wire sign_a   = sel_width(alu_byte_op, alu_op_a[7], alu_op_a[DATA_W-1]);
   wire sign_b   = sel_width(alu_byte_op, b_eff[7], b_eff[DATA_W-1]);
   wire sign_r   = sel_width(alu_byte_op, sum_full[7], sum_full[DATA_W-1]);
   wire carry_o  = sel_width(alu_byte_op, low_byte[8], sum_full[DATA_W]);
   wire half_o   = sel_width(alu_byte_op, low_nib[4], low_byte[8]);
   wire res_zero = result_is_zero(alu_byte_op, sum_full[DATA_W-1:0]);

   // software writes to the priority field are gated by the nesting lock; ipl_load is not
   wire sw_wr_status = reg_wr && (reg_addr == `CSF_OFS_STATUS);
   wire sw_wr_nest   = reg_wr && (reg_addr == `CSF_OFS_NEST_CTRL);

   // next-state of the flags; the alu update wins over a software write in the same cycle
   always @* begin
      half_carry_flag_nxt    = half_carry_flag_r;
      neg_flag_nxt           = neg_flag_r;
      signed_excess_flag_nxt = signed_excess_flag_r;
      zero_flag_nxt          = zero_flag_r;
      carry_flag_nxt         = carry_flag_r;
      cpu_priority_level_nxt = cpu_priority_level_r;
      alu_result_nxt         = alu_result_r;
      if (sw_wr_status) begin
         half_carry_flag_nxt    = reg_wdata[`CSF_BIT_HALF];
         neg_flag_nxt           = reg_wdata[`CSF_BIT_NEG];
         signed_excess_flag_nxt = reg_wdata[`CSF_BIT_EXCESS];
         zero_flag_nxt          = reg_wdata[`CSF_BIT_ZERO];
         carry_flag_nxt         = reg_wdata[`CSF_BIT_CARRY];
         if (!nesting_disable_bit_r) begin
            cpu_priority_level_nxt = reg_wdata[`CSF_IPL_HI:`CSF_IPL_LO];
         end
      end
      if (ipl_load) begin
         cpu_priority_level_nxt = ipl_load_val;
      end
      if (alu_valid) begin
         alu_result_nxt = sum_full[DATA_W-1:0];
         if (upd_half_carry) begin
            half_carry_flag_nxt = half_o;
         end
         if (upd_neg) begin
            neg_flag_nxt = sign_r;
         end
         if (upd_excess) begin
            signed_excess_flag_nxt = signed_excess(sign_a, sign_b, sign_r);
         end
         if (upd_zero) begin
            zero_flag_nxt = res_zero;
         end
         if (upd_carry) begin
            carry_flag_nxt = carry_o;
         end
      end
   end

   // flag registers, all clear at reset
   always @(posedge sys_clk) begin
      if (!reset_n) begin
         half_carry_flag_r     <= 1'b0;
         neg_flag_r            <= 1'b0;
         signed_excess_flag_r  <= 1'b0;
         zero_flag_r           <= 1'b0;
         carry_flag_r          <= 1'b0;
         cpu_priority_level_r  <= 3'h0;
         nesting_disable_bit_r <= `CSF_RST_NEST;
         alu_result_r          <= {DATA_W{1'b0}};
      end else begin
         half_carry_flag_r     <= half_carry_flag_nxt;
         neg_flag_r            <= neg_flag_nxt;
         signed_excess_flag_r  <= signed_excess_flag_nxt;
         zero_flag_r           <= zero_flag_nxt;
         carry_flag_r          <= carry_flag_nxt;
         cpu_priority_level_r  <= cpu_priority_level_nxt;
         alu_result_r          <= alu_result_nxt;
         if (sw_wr_nest) begin
            nesting_disable_bit_r <= reg_wdata[`CSF_BIT_NEST_DIS];
         end
      end
   end

   // assembled status word; upper bits are unimplemented and read zero
   assign status_word = pack_status(half_carry_flag_r, cpu_priority_level_r, repeat_running,
                                    neg_flag_r, signed_excess_flag_r, zero_flag_r, carry_flag_r);
   // full level combines the field with the externally held level bit 3
   assign cpu_level         = {ipl_level_bit3, cpu_priority_level_r};
   assign user_irq_disabled = ipl_level_bit3 || (cpu_priority_level_r == 3'h7);

   // read data one cycle after the strobe; unmapped reads return zero
   always @(posedge sys_clk) begin
      if (!reset_n) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         reg_rdata <= read_mux(reg_addr, status_word, nesting_disable_bit_r);
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

endmodule

// ---- hdl/csf_defs.vh ----
// csf_defs.vh: offsets, field positions and reset values of the cpu status flags register
// assumes inclusion by bare name from design files under hdl/
`ifndef CSF_DEFS_VH
`define CSF_DEFS_VH

// register offset on the plain register port
`define CSF_OFS_STATUS      4'h0
`define CSF_OFS_NEST_CTRL   4'h1
`define CSF_ADDR_W          4

// status register field positions
`define CSF_BIT_CARRY       0
`define CSF_BIT_ZERO        1
`define CSF_BIT_EXCESS      2
`define CSF_BIT_NEG         3
`define CSF_BIT_REPEAT      4
`define CSF_IPL_LO          5
`define CSF_IPL_HI          7
`define CSF_BIT_HALF        8

// nesting control register field position
`define CSF_BIT_NEST_DIS    0

// reset values
`define CSF_RST_STATUS      16'h0000
`define CSF_RST_NEST        1'h0

`endif

// ---- testbench/csf_exec_model.sv ----
// execution unit model: issues one alu result per call
// assumes the flags block samples on rising sys_clk
`timescale 1ns/100ps
module csf_exec_model (
   input  wire        sys_clk,
   output reg         alu_valid, alu_byte_op, alu_carry_in, alu_subtract,
   output reg         upd_half_carry, upd_neg, upd_excess, upd_zero, upd_carry,
   output reg  [15:0] alu_op_a, alu_op_b
);
   initial {alu_valid, alu_byte_op, alu_carry_in, alu_subtract, alu_op_a, alu_op_b} = 0;
   initial {upd_half_carry, upd_neg, upd_excess, upd_zero, upd_carry} = 0;
   // operands turn inverted when idle, so stale values are never trusted
   task exec(input [15:0] a, b, input [2:0] m, input [4:0] u);
      @(posedge sys_clk);
      {alu_op_a, alu_op_b, alu_byte_op, alu_carry_in, alu_subtract} <= {a, b, m};
      {upd_half_carry, upd_neg, upd_excess, upd_zero, upd_carry, alu_valid} <= {u, 1'b1};
      @(posedge sys_clk);
      alu_valid <= 1'b0;
      {alu_op_a, alu_op_b} <= ~{a, b};
   endtask
endmodule

// ---- testbench/csf_status_flags_monitor.sv ----
// port checker for the status flags block
// assumes a single sys_clk domain, bound onto the block below
`timescale 1ns/100ps
module csf_status_flags_monitor #(parameter DATA_W = 16) (
   input wire              sys_clk, reset_n, reg_wr, reg_rd, alu_valid, alu_byte_op, alu_carry_in,
   input wire              alu_subtract, upd_half_carry, upd_neg, upd_excess, upd_zero, upd_carry,
   input wire              repeat_running, ipl_load, ipl_level_bit3, user_irq_disabled,
   input wire [3:0]        reg_addr, cpu_level,
   input wire [2:0]        ipl_load_val,
   input wire [15:0]       reg_wdata, reg_rdata, status_word,
   input wire [DATA_W-1:0] alu_op_a, alu_op_b, alu_result_r
);
   // reference adder, subtract inverts b
   wire [DATA_W-1:0] bx  = alu_op_b ^ {DATA_W{alu_subtract}};
   wire [DATA_W:0]   sum = alu_op_a + bx + alu_carry_in;
   wire [8:0]        low = alu_op_a[7:0] + bx[7:0] + alu_carry_in;
   wire              wop = alu_valid && !alu_byte_op;
   reg               nest_r;
   // shadow of the nesting lock, otherwise seen at the ports only through a read of offset 1
   always @(posedge sys_clk) nest_r <= !reset_n ? 1'b0 : (reg_wr && reg_addr == 4'h1) ? reg_wdata[0] : nest_r;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   a_upper_zero: assert property (status_word[15:9] == 7'h00) else $error("upper bits set");
   a_repeat_shown: assert property (status_word[4] == repeat_running) else $error("repeat bit");
   a_level_join: assert property (cpu_level == {ipl_level_bit3, status_word[7:5]}
      && user_irq_disabled == (ipl_level_bit3 || &status_word[7:5])) else $error("level");
   a_carry_word: assert property (wop && upd_carry |=> status_word[0] == $past(sum[DATA_W])) else $error("carry");
   a_zero_word: assert property (wop && upd_zero |=> status_word[1] == $past(sum[DATA_W-1:0] == 0))
      else $error("zero");
   a_neg_half: assert property (wop && upd_neg && upd_half_carry |=> status_word[3] == $past(sum[DATA_W-1])
      && status_word[8] == $past(low[8])) else $error("neg or half");
   a_flags_hold: assert property (!alu_valid && !reg_wr |=> $stable({status_word[8], status_word[3:0]}))
      else $error("flag moved");
   a_ipl_locked: assert property (reg_wr && reg_addr == 4'h0 && nest_r && !ipl_load |=> $stable(status_word[7:5]))
      else $error("locked field moved");
   a_read_late: assert property (reg_rd && reg_addr == 4'h0 |=> reg_rdata == $past(status_word)) else $error("read");
   c_locked_write: cover property (reg_wr && nest_r);
   c_carry_out: cover property (wop && sum[DATA_W]);
   c_repeat_read: cover property (repeat_running && reg_rd);
endmodule
bind csf_status_flags csf_status_flags_monitor #(.DATA_W(DATA_W)) csf_status_flags_monitor_i (.*);

// ---- testbench/tb.sv ----
// self-checking bench for the status flags block
// assumes the exec model drives the alu side, the bench drives the rest
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; $display("unexpected at %0t: %h vs %h", $time, g, e); end end
module tb;
   logic        sys_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, repeat_running = 0, ipl_load = 0, ipl_level_bit3 = 0;
   logic [3:0]  reg_addr = 0;
   logic [2:0]  ipl_load_val = 0;
   logic [15:0] reg_wdata = 0;
   wire         alu_valid, alu_byte_op, alu_carry_in, alu_subtract, user_irq_disabled;
   wire         upd_half_carry, upd_neg, upd_excess, upd_zero, upd_carry;
   wire [15:0]  alu_op_a, alu_op_b, reg_rdata, status_word, alu_result_r;
   wire [3:0]   cpu_level;
   int          num_errors = 0, comparisons = 0, cyc = 0;
   // rows: a, b, {byte, carry in, subtract}, expected status word
   logic [50:0] rows [5] = '{{16'h7FFF, 16'h0001, 3'h0, 16'h010C}, {16'hFFFF, 16'h0001, 3'h0, 16'h0103},
      {16'h0003, 16'h0005, 3'h3, 16'h0008}, {16'h8000, 16'h8000, 3'h0, 16'h0007}, {16'h0012, 16'h0034, 3'h0, 16'h0000}};
   csf_status_flags csf_status_flags_i (.*);
   csf_exec_model csf_exec_model_i (.*);
   task close_out;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // one-cycle strobes, released at the next edge
   task wr(input [3:0] a, input [15:0] d);
      @(posedge sys_clk);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input [3:0] a, input [15:0] e);
      @(posedge sys_clk);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      `CHK(reg_rdata, e)
   endtask
   task st(input [15:0] e);
      @(negedge sys_clk);
      `CHK(status_word, e)
   endtask
   initial forever #2 sys_clk = ~sys_clk;
   // hang guard, the run needs under a hundred cycles
   always @(posedge sys_clk) if (++cyc > 1000) begin num_errors++; close_out; end
   initial begin
      repeat (4) @(posedge sys_clk);
      reset_n <= 1'b1;
      st(16'h0000);
      foreach (rows[i]) begin
         csf_exec_model_i.exec(rows[i][50:35], rows[i][34:19], rows[i][18:16], 5'h1F);
         st(rows[i][15:0]);
         `CHK(alu_result_r, 16'(rows[i][50:35] + (rows[i][34:19] ^ {16{rows[i][16]}}) + rows[i][17]))
      end
      csf_exec_model_i.exec(16'hFFFF, 16'h0001, 3'h0, 5'h01);
      st(16'h0001);
      csf_exec_model_i.exec(16'h0000, 16'h0000, 3'h0, 5'h02);
      st(16'h0003);
      csf_exec_model_i.exec(16'h000F, 16'h0001, 3'h4, 5'h10);
      st(16'h0103);
      wr(4'h0, 16'hFFFF);
      rd(4'h0, 16'h01EF);
      @(posedge sys_clk) repeat_running <= 1'b1;
      rd(4'h0, 16'h01FF);
      `CHK({cpu_level, user_irq_disabled}, 5'h0F)
      wr(4'h1, 16'h0001);
      rd(4'h1, 16'h0001);
      wr(4'h0, 16'h0000);
      st(16'h00F0);
      @(posedge sys_clk) {ipl_load, ipl_load_val, ipl_level_bit3} <= {1'b1, 3'h2, 1'b1};
      @(posedge sys_clk) ipl_load <= 1'b0;
      st(16'h0050);
      `CHK({cpu_level, user_irq_disabled}, 5'h15)
      wr(4'h1, 16'h0000);
      wr(4'h0, 16'h00C0);
      st(16'h00D0);
      wr(4'h5, 16'hFFFF);
      rd(4'h5, 16'h0000);
      st(16'h00D0);
      @(posedge sys_clk) {reset_n, repeat_running} <= 2'b00;
      @(posedge sys_clk) reset_n <= 1'b1;
      st(16'h0000);
      close_out;
   end
endmodule
